//--- rtl/vwc_pkg.sv
// Constants for the video window crop and scale block
package vwc_pkg;
    // ------------------------------------------------------------
    // Register indices; byte address is four times the index
    // ------------------------------------------------------------
    localparam logic [13:0] IDX_FIELD_LINES = 14'h012b;
    localparam logic [13:0] IDX_OUT_LINES   = 14'h012c;
    localparam logic [13:0] IDX_HSTART      = 14'h012d;
    localparam logic [13:0] IDX_HLEN        = 14'h012e;
    localparam logic [13:0] IDX_NPIX        = 14'h012f;
    localparam logic [13:0] IDX_STATUS      = 14'h0140;
    localparam logic [13:0] IDX_SRC_PIX     = 14'h0141;

    // ------------------------------------------------------------
    // Field layouts
    // ------------------------------------------------------------
    localparam int LINES_W     = 9;
    localparam int PIX_W       = 11;
    localparam int FMODE_LSB   = 10;
    localparam int ST_ODD_BIT  = 9;
    localparam int ST_KEEP_BIT = 10;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [8:0]  RST_IN_LINES  = 9'h1f4;
    localparam logic [1:0]  RST_FMODE     = 2'h0;
    localparam logic [8:0]  RST_OUT_LINES = 9'h0f0;
    localparam logic [10:0] RST_HSTART    = 11'h000;
    localparam logic [10:0] RST_HLEN      = 11'h280;
    localparam logic [10:0] RST_NPIX      = 11'h280;
    localparam logic [10:0] RST_SRC_PIX   = 11'h2d0;

    // ------------------------------------------------------------
    // Field enable codes
    // ------------------------------------------------------------
    localparam logic [1:0] FMODE_BOTH = 2'h0;
    localparam logic [1:0] FMODE_EVEN = 2'h1;
    localparam logic [1:0] FMODE_ODD  = 2'h2;
    localparam logic [1:0] FMODE_OFF  = 2'h3;

    typedef enum logic [0:0] {
        BUS_IDLE,
        BUS_RDWAIT
    } vwc_bus_state_type;
endpackage

//--- rtl/vwc_fifo.sv
// Synchronous FIFO with valid/ready on both sides
`timescale 1ns/10ps
`default_nettype none
module vwc_fifo #(
    parameter int WIDTH = 18,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input  wire logic                     hclk,
    input  wire logic                     hresetn,
    // Fill side
    input  wire logic                     in_valid,
    output logic                          in_ready,
    input  wire logic [WIDTH-1:0]         in_data,
    // Drain side
    output logic                          out_valid,
    input  wire logic                     out_ready,
    output logic [WIDTH-1:0]              out_data,
    // Fill level
    output logic [$clog2(DEPTH):0]        count
);
    localparam int AW = $clog2(DEPTH);

    if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin
        $error("vwc_fifo: DEPTH must be a power of two >= 2");
    end

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wr_ptr_ff;
    logic [AW:0]      rd_ptr_ff;
    logic             push;
    logic             pop;

    assign count     = wr_ptr_ff - rd_ptr_ff;
    assign in_ready  = (count != DEPTH[AW:0] + {(AW+1){1'b0}}) ||
                       (wr_ptr_ff[AW-1:0] != rd_ptr_ff[AW-1:0]);
    assign out_valid = (wr_ptr_ff != rd_ptr_ff);
    assign out_data  = mem[rd_ptr_ff[AW-1:0]];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_ff @(posedge hclk) begin
        if (push) begin
            mem[wr_ptr_ff[AW-1:0]] <= in_data;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
        end else begin
            if (push) begin
                wr_ptr_ff <= wr_ptr_ff + 1'b1;
            end
            if (pop) begin
                rd_ptr_ff <= rd_ptr_ff + 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

//--- rtl/vwc_hresize.sv
// Nearest-neighbour horizontal resizer, source pixels to scaled pixels
`timescale 1ns/10ps
`default_nettype none
module vwc_hresize #(
    parameter int DW = 16,
    parameter int CW = 11
) (
    // Clock and reset
    input  wire logic          hclk,
    input  wire logic          hresetn,
    // Ratio
    input  wire logic [CW-1:0] src_pixels,
    input  wire logic [CW-1:0] dst_pixels,
    // Source pixels
    input  wire logic          in_valid,
    output logic               in_ready,
    input  wire logic [DW-1:0] in_data,
    input  wire logic          in_first,
    // Scaled pixels
    output logic               out_valid,
    input  wire logic          out_ready,
    output logic [DW-1:0]      out_data
);
    if (CW < 2 || DW < 1) begin
        $error("vwc_hresize: widths too small");
    end

    logic [CW+1:0] acc_ff;
    logic [DW-1:0] pix_ff;
    logic          held_ff;
    logic          can_emit;

    // Each source pixel adds dst, each output takes src: total is dst
    assign can_emit  = held_ff && (acc_ff >= {2'b00, src_pixels});
    assign out_valid = can_emit;
    assign out_data  = pix_ff;
    assign in_ready  = !can_emit;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            acc_ff  <= '0;
            pix_ff  <= '0;
            held_ff <= 1'b0;
        end else if (can_emit) begin
            if (out_ready) begin
                acc_ff <= acc_ff - {2'b00, src_pixels};
            end
        end else if (in_valid) begin
            pix_ff  <= in_data;
            held_ff <= 1'b1;
            // Restart per line so rounding residue never carries over
            acc_ff  <= (in_first ? '0 : acc_ff) + {2'b00, dst_pixels};
        end
    end
endmodule
`default_nettype wire

//--- rtl/vwc_top.sv
// Video window two: field select, line drop, scale and crop, AHB regs
`timescale 1ns/10ps
`default_nettype none
module vwc_top #(
    parameter int DW         = 16,
    parameter int FIFO_DEPTH = 16
) (
    // Clock and reset
    input  wire logic          hclk,
    input  wire logic          hresetn,
    // AHB-Lite slave
    input  wire logic          hsel,
    input  wire logic [15:0]   haddr,
    input  wire logic [1:0]    htrans,
    input  wire logic          hwrite,
    input  wire logic [2:0]    hsize,
    input  wire logic [31:0]   hwdata,
    input  wire logic          hready,
    output logic               hreadyout,
    output logic [31:0]        hrdata,
    output logic               hresp,
    // Decoded pixel stream in
    input  wire logic          field_start,
    input  wire logic          field_odd,
    input  wire logic          pix_in_valid,
    output logic               pix_in_ready,
    input  wire logic [DW-1:0] pix_in_data,
    input  wire logic          pix_in_first,
    // Window pixel stream out
    output logic               pix_out_valid,
    input  wire logic          pix_out_ready,
    output logic [DW-1:0]      pix_out_data,
    output logic               pix_out_first,
    output logic               pix_out_last
);
    localparam int LW = vwc_pkg::LINES_W;
    localparam int PW = vwc_pkg::PIX_W;
    localparam int FW = DW + 2;
    if (FIFO_DEPTH < 4 || DW < 1) begin
        $error("vwc_top: FIFO_DEPTH must be at least 4");
    end
    // ------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------
    logic [LW-1:0] input_line_total_ff;
    logic [1:0]    field_mode_ff;
    logic [LW-1:0] output_line_count_ff;
    logic [PW-1:0] crop_start_pixel_ff;
    logic [PW-1:0] crop_length_pixels_ff;
    logic [PW-1:0] scaled_line_pixels_ff;
    logic [PW-1:0] source_line_pixels_ff;

    // ------------------------------------------------------------
    // AHB-Lite slave
    // ------------------------------------------------------------
    vwc_pkg::vwc_bus_state_type bus_state_ff;
    logic          wr_pend_ff;
    logic [13:0]   wr_idx_ff;
    logic [13:0]   rd_idx_ff;
    logic          hreadyout_ff;
    logic [31:0]   hrdata_ff;
    logic          addr_ok;
    logic [11:0]   rd_word;

    assign addr_ok = hsel && htrans[1] && hready;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bus_state_ff <= vwc_pkg::BUS_IDLE;
            hreadyout_ff <= 1'b1;
            wr_pend_ff   <= 1'b0;
            wr_idx_ff    <= '0;
            rd_idx_ff    <= '0;
        end else begin
            case (bus_state_ff)
                vwc_pkg::BUS_IDLE: begin
                    wr_pend_ff <= addr_ok && hwrite;
                    wr_idx_ff  <= haddr[15:2];
                    // One wait state so a read never races a write
                    if (addr_ok && !hwrite) begin
                        rd_idx_ff    <= haddr[15:2];
                        hreadyout_ff <= 1'b0;
                        bus_state_ff <= vwc_pkg::BUS_RDWAIT;
                    end
                end
                vwc_pkg::BUS_RDWAIT: begin
                    wr_pend_ff   <= 1'b0;
                    hreadyout_ff <= 1'b1;
                    bus_state_ff <= vwc_pkg::BUS_IDLE;
                end
                default: bus_state_ff <= vwc_pkg::BUS_IDLE;
            endcase
        end
    end
    // Register writes keep only defined bits; reserved bits stay zero
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            input_line_total_ff   <= vwc_pkg::RST_IN_LINES;
            field_mode_ff         <= vwc_pkg::RST_FMODE;
            output_line_count_ff  <= vwc_pkg::RST_OUT_LINES;
            crop_start_pixel_ff   <= vwc_pkg::RST_HSTART;
            crop_length_pixels_ff <= vwc_pkg::RST_HLEN;
            scaled_line_pixels_ff <= vwc_pkg::RST_NPIX;
            source_line_pixels_ff <= vwc_pkg::RST_SRC_PIX;
        end else if (wr_pend_ff) begin
            case (wr_idx_ff)
                vwc_pkg::IDX_FIELD_LINES: begin
                    input_line_total_ff <= hwdata[LW-1:0];
                    field_mode_ff <= hwdata[vwc_pkg::FMODE_LSB +: 2];
                end
                vwc_pkg::IDX_OUT_LINES: output_line_count_ff <= hwdata[LW-1:0];
                vwc_pkg::IDX_HSTART: crop_start_pixel_ff <= hwdata[PW-1:0];
                vwc_pkg::IDX_HLEN: crop_length_pixels_ff <= hwdata[PW-1:0];
                vwc_pkg::IDX_NPIX: scaled_line_pixels_ff <= hwdata[PW-1:0];
                vwc_pkg::IDX_SRC_PIX: source_line_pixels_ff <= hwdata[PW-1:0];
                default: ;
            endcase
        end
    end
    // ------------------------------------------------------------
    // Vertical state; kept line count, field and keep flag also shown in the status register
    // ------------------------------------------------------------
    logic [LW-1:0] line_idx_ff;
    logic [LW-1:0] lines_out_ff;
    logic [LW:0]   vacc_ff;
    logic          field_odd_ff;
    logic          line_keep_ff;

    always_comb begin
        rd_word = 12'h000;
        case (rd_idx_ff)
            vwc_pkg::IDX_FIELD_LINES: begin
                rd_word[LW-1:0] = input_line_total_ff;
                rd_word[vwc_pkg::FMODE_LSB +: 2] = field_mode_ff;
            end
            vwc_pkg::IDX_OUT_LINES: rd_word[LW-1:0] = output_line_count_ff;
            vwc_pkg::IDX_HSTART:    rd_word[PW-1:0] = crop_start_pixel_ff;
            vwc_pkg::IDX_HLEN:      rd_word[PW-1:0] = crop_length_pixels_ff;
            vwc_pkg::IDX_NPIX:      rd_word[PW-1:0] = scaled_line_pixels_ff;
            vwc_pkg::IDX_SRC_PIX:   rd_word[PW-1:0] = source_line_pixels_ff;
            vwc_pkg::IDX_STATUS: begin
                rd_word[LW-1:0] = lines_out_ff;
                rd_word[vwc_pkg::ST_ODD_BIT]  = field_odd_ff;
                rd_word[vwc_pkg::ST_KEEP_BIT] = line_keep_ff;
            end
            default: rd_word = 12'h000;
        endcase
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_ff <= '0;
        end else if (bus_state_ff == vwc_pkg::BUS_RDWAIT) begin
            hrdata_ff <= {20'h00000, rd_word};
        end
    end
    assign hreadyout = hreadyout_ff;
    assign hrdata    = hrdata_ff;
    assign hresp     = 1'b0;
    // ------------------------------------------------------------
    // Input holding stage; ready comes from a flop
    // ------------------------------------------------------------
    logic          hold_valid_ff;
    logic [DW-1:0] hold_data_ff;
    logic          hold_first_ff;
    logic          pix_in_ready_ff;
    logic          rs_in_ready;
    logic          hold_take;
    logic          accept;
    logic          nxt_hold_valid;

    // Half rate input traded for a registered ready with no skid logic
    assign accept         = pix_in_valid && pix_in_ready_ff;
    assign hold_take      = hold_valid_ff && rs_in_ready;
    assign nxt_hold_valid = accept || (hold_valid_ff && !hold_take);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hold_valid_ff   <= 1'b0;
            hold_data_ff    <= '0;
            hold_first_ff   <= 1'b0;
            pix_in_ready_ff <= 1'b0;
        end else begin
            hold_valid_ff   <= nxt_hold_valid;
            pix_in_ready_ff <= !nxt_hold_valid;
            if (accept) begin
                hold_data_ff  <= pix_in_data;
                hold_first_ff <= pix_in_first;
            end
        end
    end

    assign pix_in_ready = pix_in_ready_ff;
    // ------------------------------------------------------------
    // Vertical window: field select and even line dropping
    // ------------------------------------------------------------
    logic          line_start;
    logic          field_on;
    logic          in_range;
    logic [LW:0]   vacc_sum;

    assign line_start = hold_take && hold_first_ff;
    assign in_range   = line_idx_ff < input_line_total_ff;
    assign vacc_sum   = vacc_ff + {1'b0, output_line_count_ff};

    always_comb begin
        case (field_mode_ff)
            vwc_pkg::FMODE_BOTH: field_on = 1'b1;
            vwc_pkg::FMODE_EVEN: field_on = !field_odd_ff;
            vwc_pkg::FMODE_ODD:  field_on = field_odd_ff;
            default:             field_on = 1'b0;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            line_idx_ff  <= '0;
            lines_out_ff <= '0;
            vacc_ff      <= '0;
            field_odd_ff <= 1'b0;
            line_keep_ff <= 1'b0;
        end else if (field_start) begin
            line_idx_ff  <= '0;
            lines_out_ff <= '0;
            vacc_ff      <= '0;
            field_odd_ff <= field_odd;
            line_keep_ff <= 1'b0;
        end else if (line_start) begin
            if (line_idx_ff != {LW{1'b1}}) begin
                line_idx_ff <= line_idx_ff + 1'b1;
            end
            line_keep_ff <= 1'b0;
            if (in_range && field_on &&
                lines_out_ff < output_line_count_ff) begin
                // Keep a line each time the ratio accumulator wraps
                if (vacc_sum >= {1'b0, input_line_total_ff}) begin
                    vacc_ff      <= vacc_sum - {1'b0, input_line_total_ff};
                    line_keep_ff <= 1'b1;
                    lines_out_ff <= lines_out_ff + 1'b1;
                end else begin
                    vacc_ff <= vacc_sum;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Horizontal scaling and crop
    // ------------------------------------------------------------
    logic          rs_valid;
    logic [DW-1:0] rs_data;
    logic          rs_ready;
    logic [PW-1:0] hpos_ff;
    logic [PW:0]   crop_end;
    logic          in_crop;
    logic          fifo_in_ready;
    logic          fifo_in_valid;

    vwc_hresize #(
        .DW (DW),
        .CW (PW)
    ) u_hresize (
        .hclk       (hclk),
        .hresetn    (hresetn),
        .src_pixels (source_line_pixels_ff),
        .dst_pixels (scaled_line_pixels_ff),
        .in_valid   (hold_valid_ff),
        .in_ready   (rs_in_ready),
        .in_data    (hold_data_ff),
        .in_first   (hold_first_ff),
        .out_valid  (rs_valid),
        .out_ready  (rs_ready),
        .out_data   (rs_data)
    );
    assign crop_end = {1'b0, crop_start_pixel_ff} +
                      {1'b0, crop_length_pixels_ff};
    assign in_crop  = line_keep_ff &&
                      hpos_ff >= crop_start_pixel_ff &&
                      {1'b0, hpos_ff} < crop_end;
    // Pixels outside the window are discarded without waiting
    assign fifo_in_valid = rs_valid && in_crop;
    assign rs_ready      = !in_crop || fifo_in_ready;
    // Position along the scaled line
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hpos_ff <= '0;
        end else if (line_start) begin
            hpos_ff <= '0;
        end else if (rs_valid && rs_ready && hpos_ff != {PW{1'b1}}) begin
            hpos_ff <= hpos_ff + 1'b1;
        end
    end
    // ------------------------------------------------------------
    // Output FIFO and registered output stage
    // ------------------------------------------------------------
    logic [FW-1:0] fifo_in_word;
    logic [FW-1:0] fifo_out_word;
    logic          fifo_out_valid;
    logic          fifo_out_ready;
    logic          out_valid_ff;
    logic [DW-1:0] out_data_ff;
    logic          out_first_ff;
    logic          out_last_ff;
    assign fifo_in_word = {hpos_ff == crop_start_pixel_ff,
                           {1'b0, hpos_ff} == crop_end - 1'b1, rs_data};
    vwc_fifo #(
        .WIDTH (FW),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .in_valid  (fifo_in_valid),
        .in_ready  (fifo_in_ready),
        .in_data   (fifo_in_word),
        .out_valid (fifo_out_valid),
        .out_ready (fifo_out_ready),
        .out_data  (fifo_out_word),
        .count     ()
    );
    assign fifo_out_ready = !out_valid_ff || pix_out_ready;
    // Flags gated: an empty buffer shows a stale word with flags cleared
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            out_valid_ff <= 1'b0;
            out_data_ff  <= '0;
            out_first_ff <= 1'b0;
            out_last_ff  <= 1'b0;
        end else if (fifo_out_ready) begin
            out_valid_ff <= fifo_out_valid;
            out_data_ff  <= fifo_out_word[DW-1:0];
            out_last_ff  <= fifo_out_valid && fifo_out_word[DW];
            out_first_ff <= fifo_out_valid && fifo_out_word[DW+1];
        end
    end
    assign pix_out_valid = out_valid_ff;
    assign pix_out_data  = out_data_ff;
    assign pix_out_first = out_first_ff;
    assign pix_out_last  = out_last_ff;
endmodule
`default_nettype wire

//--- tb/vwc_asserts.sv
// Port checker for the video window block
`timescale 1ns/10ps
`default_nettype none
module vwc_asserts #(
    parameter int DW = 16
) (
    // Bus
    input wire logic          hclk,
    input wire logic          hresetn,
    input wire logic          hsel,
    input wire logic [1:0]    htrans,
    input wire logic          hwrite,
    input wire logic          hready,
    input wire logic          hreadyout,
    input wire logic [31:0]   hrdata,
    input wire logic          hresp,
    // Pixels
    input wire logic          pix_in_valid,
    input wire logic          pix_in_ready,
    input wire logic          pix_out_valid,
    input wire logic          pix_out_ready,
    input wire logic [DW-1:0] pix_out_data,
    input wire logic          pix_out_first,
    input wire logic          pix_out_last
);
    // ------------------------------------------------------------
    // Bus and stream timing
    // ------------------------------------------------------------
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    sequence rd_take;
        hsel && htrans[1] && hready && !hwrite;
    endsequence
    sequence rd_answer;
        !hreadyout ##1 hreadyout;
    endsequence
    rd_wait_a: assert property (rd_take |=> rd_answer)
        else $error("read wait state wrong");
    wr_nowait_a: assert property (hsel && htrans[1] && hready && hwrite
        |=> hreadyout) else $error("write stalled");
    resp_okay_a: assert property (hresp == 1'b0)
        else $error("response not okay");
    rdata_top_a: assert property (hrdata[31:12] == 20'h0)
        else $error("read data upper bits set");
    rd_hold_a: assert property ($changed(hrdata) |->
        !hreadyout || $rose(hreadyout)) else $error("read data moved");
    in_gap_a: assert property (pix_in_valid && pix_in_ready
        |=> !pix_in_ready) else $error("input accepted twice in a row");
    out_hold_a: assert property (pix_out_valid && !pix_out_ready |=>
        pix_out_valid && $stable(pix_out_data) && $stable(pix_out_first)
        && $stable(pix_out_last)) else $error("stalled pixel changed");
    flag_valid_a: assert property (pix_out_first || pix_out_last
        |-> pix_out_valid) else $error("line flag without pixel");
endmodule
bind vwc_top vwc_asserts #(.DW(DW)) u_asserts (
    .hclk, .hresetn, .hsel, .htrans, .hwrite, .hready, .hreadyout,
    .hrdata, .hresp, .pix_in_valid, .pix_in_ready, .pix_out_valid,
    .pix_out_ready, .pix_out_data, .pix_out_first, .pix_out_last);
`default_nettype wire

//--- tb/testbench.sv
// Self-checking bench for the video window block
`timescale 1ns/10ps
`default_nettype none
module testbench;
    logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
    logic        field_start, field_odd, pix_in_valid, pix_in_ready;
    logic        pix_in_first, pix_out_valid, pix_out_ready;
    logic        pix_out_first, pix_out_last;
    logic [15:0] haddr, pix_in_data, pix_out_data;
    logic [1:0]  htrans;
    logic [31:0] hwdata, hrdata, rd;
    logic [17:0] got[$];
    int          fail_count, n_compared;

    vwc_top uut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
        .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hrdata,
        .hresp, .field_start, .field_odd, .pix_in_valid, .pix_in_ready,
        .pix_in_data, .pix_in_first, .pix_out_valid, .pix_out_ready,
        .pix_out_data, .pix_out_first, .pix_out_last);

    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end
    always @(posedge hclk)
        if (pix_out_valid && pix_out_ready)
            got.push_back({pix_out_first, pix_out_last, pix_out_data});

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task stop_test;
        $display("compared %0d, errors %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task chk(input logic [31:0] g, input logic [31:0] e, input string m);
        n_compared++;
        if (g !== e) begin
            fail_count++;
            $display("Error at %0t: %s", $time, m);
        end
    endtask
    task tmo;
        fail_count++;
        $display("Error at %0t: timeout", $time);
        stop_test;
    endtask
    task edge_rdy;
        for (int i = 0; i < 50; i++) begin
            @(posedge hclk);
            if (hreadyout === 1'b1) return;
        end
        tmo;
    endtask
    task bus(input logic w, input logic [13:0] x, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {x, 2'h0};
        hwrite <= w;
        edge_rdy;
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        edge_rdy;
        rd = hrdata;
    endtask
    task rchk(input logic [13:0] x, input logic [31:0] e);
        bus(1'b0, x, 32'h0);
        chk(rd, e, "register read");
    endtask
    task cfg(input logic [11:0] fl, ol, src, np, hs, hl);
        bus(1'b1, vwc_pkg::IDX_FIELD_LINES, {20'h0, fl});
        bus(1'b1, vwc_pkg::IDX_OUT_LINES, {20'h0, ol});
        bus(1'b1, vwc_pkg::IDX_SRC_PIX, {20'h0, src});
        bus(1'b1, vwc_pkg::IDX_NPIX, {20'h0, np});
        bus(1'b1, vwc_pkg::IDX_HSTART, {20'h0, hs});
        bus(1'b1, vwc_pkg::IDX_HLEN, {20'h0, hl});
        got.delete();
    endtask
    // Holds each pixel until the block takes it
    task field(input logic odd, input int lines, input int n);
        int i;
        field_start <= 1'b1;
        field_odd <= odd;
        @(posedge hclk);
        field_start <= 1'b0;
        for (int l = 0; l < lines; l++)
            for (int k = 0; k < n; k++) begin
                pix_in_valid <= 1'b1;
                pix_in_data <= {l[7:0], k[7:0]};
                pix_in_first <= (k == 0);
                for (i = 0; i < 400; i++) begin
                    @(posedge hclk);
                    if (pix_in_ready === 1'b1) break;
                end
                if (i == 400) tmo;
            end
        pix_in_valid <= 1'b0;
        pix_in_first <= 1'b0;
        repeat (300) @(posedge hclk);
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task t_regs;
        rchk(vwc_pkg::IDX_FIELD_LINES, 32'h1f4);
        rchk(vwc_pkg::IDX_OUT_LINES, 32'h0f0);
        rchk(vwc_pkg::IDX_HSTART, 32'h0);
        rchk(vwc_pkg::IDX_HLEN, 32'h280);
        rchk(vwc_pkg::IDX_NPIX, 32'h280);
        rchk(vwc_pkg::IDX_SRC_PIX, 32'h2d0);
        bus(1'b1, vwc_pkg::IDX_HSTART, 32'hffff_ffff);
        rchk(vwc_pkg::IDX_HSTART, 32'h7ff);
        bus(1'b1, 14'h0100, 32'h5a5);
        rchk(14'h0100, 32'h0);
    endtask
    // Sink stalls long enough to fill the buffer and block the source
    task t_crop;
        cfg(12'h004, 12'h004, 12'h020, 12'h020, 12'h005, 12'h014);
        pix_out_ready <= 1'b0;
        fork
            field(1'b1, 1, 32);
            begin
                repeat (150) @(posedge hclk);
                pix_out_ready <= 1'b1;
            end
        join
        chk(got.size(), 20, "crop length");
        for (int j = 0; j < 20; j++)
            chk(got[j], {j == 0, j == 19, 8'h0, 8'(j + 5)}, "crop");
    endtask
    task t_fields;
        logic [1:0] m;
        logic       on;
        for (int q = 0; q < 8; q++) begin
            m = q[2:1];
            on = m == vwc_pkg::FMODE_BOTH || (m == vwc_pkg::FMODE_ODD &&
                q[0]) || (m == vwc_pkg::FMODE_EVEN && !q[0]);
            cfg({m, 10'h004}, 12'h004, 12'h020, 12'h020, 12'h0, 12'h008);
            field(q[0], 1, 32);
            chk(got.size(), on ? 8 : 0, "field select");
        end
    endtask
    task t_drop;
        cfg(12'h004, 12'h002, 12'h020, 12'h020, 12'h0, 12'h020);
        field(1'b0, 5, 32);
        chk(got.size(), 64, "dropped line count");
        chk(got[0], 18'h20100, "first kept line");
        chk(got[32], 18'h20300, "second kept line");
        rchk(vwc_pkg::IDX_STATUS, 32'h002);
    endtask
    task t_scale;
        for (int s = 0; s < 2; s++) begin
            cfg(12'h004, 12'h004, s ? 12'h020 : 12'h040,
                s ? 12'h040 : 12'h020, 12'h0, s ? 12'h040 : 12'h020);
            field(1'b1, 1, s ? 32 : 64);
            chk(got.size(), s ? 64 : 32, "scaled count");
            chk(got[got.size() - 1][16], 1'b1, "scaled last");
        end
    endtask

    initial begin
        {hresetn, hsel, hwrite, field_start, field_odd} = 5'h0;
        {pix_in_valid, pix_in_first, htrans, haddr} = 20'h0;
        {hwdata, pix_in_data} = 48'h0;
        pix_out_ready = 1'b1;
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_regs;
        t_crop;
        t_fields;
        t_drop;
        t_scale;
        stop_test;
    end
endmodule
`default_nettype wire
